/* File: core/monitor2_pkg.sv */
package monitor2_pkg;
  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h0f6;
  localparam logic [ADDR_W-1:0] STAT_IDX = 12'h0f7;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX[ADDR_W-3:0], 2'b00};
  // Control field positions and widths
  localparam int PTR_LSB = 0;
  localparam int PTR_W = 14;
  localparam int POL_BIT = 14;
  localparam int FRAC_LSB = 15;
  localparam int EXP_LSB = 19;
  localparam int GAIN_W = 4;
  localparam int CTRL_W = 23;
  // Control reset values
  localparam logic [PTR_W-1:0] PTR_RST = 14'h0000;
  localparam logic POL_RST = 1'b0;
  localparam logic [GAIN_W-1:0] FRAC_RST = 4'h8;
  localparam logic [GAIN_W-1:0] EXP_RST = 4'h0;
  // Status field positions
  localparam int STAT_SAT_BIT = 16;
  localparam int STAT_ENUM_BIT = 17;
  // Data path widths and scaling
  localparam int VAR_W = 32;
  localparam int WIDE_W = 72;
  localparam int CODE_W = 12;
  localparam int PU_FRAC = 27;
  localparam int FRAC_DEN_SHIFT = 3;
  localparam int ENUM_PU_SHIFT = 5;
  localparam int ENUM_MAX = 31;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h800;

  typedef struct packed {
    logic [GAIN_W-1:0] exp_gain;
    logic [GAIN_W-1:0] frac_gain;
    logic polarity;
    logic [PTR_W-1:0] pointer;
  } ctrl_t;

  typedef struct packed {
    logic enum_mode;
    logic saturated;
    logic [CODE_W-1:0] code;
  } stat_t;
endpackage : monitor2_pkg

/* File: core/dac_monitor_channel_two.sv */
// Function
// - A 14-bit read-write pointer in control bits 13:0 picks the algorithm variable shown on output two.
// - A nonzero fraction gain N in bits 18:15 scales the variable by N/8, and it resets to 8 for unity gain.
// - A zero fraction gain makes the variable an enumerated value with maximum 31 instead of a per-unit value.
// - The variable is scaled by two to the power of the exponent gain in bits 22:19 only while fraction is zero.
// - With polarity bit 14 set, zero per-unit gives 0 V and one per-unit gives 3 V with no offset.
// - With polarity bit 14 clear, its reset value, minus one per-unit gives 0 V, plus one gives full scale, zero 1.5 V.
module dac_monitor_channel_two (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [monitor2_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [monitor2_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [monitor2_pkg::DATA_W-1:0] reg_rdata,
  // Algorithm variable fetch
  output logic [monitor2_pkg::PTR_W-1:0] var_pointer,
  input wire logic [monitor2_pkg::VAR_W-1:0] var_data,
  input wire logic var_valid,
  // Converter code
  output logic [monitor2_pkg::CODE_W-1:0] dac_code,
  output logic dac_update
);

  monitor2_pkg::ctrl_t ctrl_r;
  monitor2_pkg::stat_t stat_r;
  logic [monitor2_pkg::DATA_W-1:0] rdata_r;
  logic [monitor2_pkg::CODE_W-1:0] code_r;
  logic update_r;
  logic signed [monitor2_pkg::WIDE_W-1:0] scaled_r;
  logic scaled_vld_r;
  logic enum_mode_r;
  logic polarity_s_r;

  logic signed [monitor2_pkg::WIDE_W-1:0] var_wide;
  logic signed [monitor2_pkg::WIDE_W-1:0] frac_prod;
  logic signed [monitor2_pkg::WIDE_W-1:0] scaled_nxt;
  logic signed [monitor2_pkg::WIDE_W-1:0] pre_code;
  logic [monitor2_pkg::CODE_W-1:0] code_nxt;
  logic sat_nxt;
  logic [monitor2_pkg::DATA_W-1:0] rdata_nxt;

  // Control register write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r.pointer <= monitor2_pkg::PTR_RST;
      ctrl_r.polarity <= monitor2_pkg::POL_RST;
      ctrl_r.frac_gain <= monitor2_pkg::FRAC_RST;
      ctrl_r.exp_gain <= monitor2_pkg::EXP_RST;
    end
    else if (reg_wr && reg_addr == monitor2_pkg::CTRL_ADDR)
    begin
      ctrl_r <= reg_wdata[monitor2_pkg::CTRL_W-1:0];
    end
  end

  // Register read, data valid in the following cycle only
  always_comb
  begin
    rdata_nxt = '0;
    if (reg_rd && reg_addr == monitor2_pkg::CTRL_ADDR)
    begin
      // Gain and polarity fields are write-only and read as zero
      rdata_nxt[monitor2_pkg::PTR_LSB +: monitor2_pkg::PTR_W] = ctrl_r.pointer;
    end
    else if (reg_rd && reg_addr == monitor2_pkg::STAT_ADDR)
    begin
      rdata_nxt[monitor2_pkg::CODE_W-1:0] = stat_r.code;
      rdata_nxt[monitor2_pkg::STAT_SAT_BIT] = stat_r.saturated;
      rdata_nxt[monitor2_pkg::STAT_ENUM_BIT] = stat_r.enum_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Gain stage
  always_comb
  begin
    var_wide = {{(monitor2_pkg::WIDE_W-monitor2_pkg::VAR_W){var_data[monitor2_pkg::VAR_W-1]}}, var_data};
    frac_prod = var_wide * $signed({1'b0, ctrl_r.frac_gain});
    if (ctrl_r.frac_gain != '0)
    begin
      scaled_nxt = frac_prod >>> monitor2_pkg::FRAC_DEN_SHIFT;
    end
    else
    begin
      // Enumerated value: 32 counts stand for one per-unit, so 31 sits just below full scale
      scaled_nxt = var_wide <<< (monitor2_pkg::PU_FRAC - monitor2_pkg::ENUM_PU_SHIFT);
      scaled_nxt = scaled_nxt <<< ctrl_r.exp_gain;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scaled_r <= '0;
      scaled_vld_r <= 1'b0;
      enum_mode_r <= 1'b0;
      polarity_s_r <= monitor2_pkg::POL_RST;
    end
    else
    begin
      scaled_vld_r <= var_valid;
      if (var_valid)
      begin
        scaled_r <= scaled_nxt;
        enum_mode_r <= (ctrl_r.frac_gain == '0);
        polarity_s_r <= ctrl_r.polarity;
      end
    end
  end

  // Output mapping and saturation
  always_comb
  begin
    if (polarity_s_r)
    begin
      pre_code = scaled_r >>> (monitor2_pkg::PU_FRAC - monitor2_pkg::CODE_W);
    end
    else
    begin
      pre_code = (scaled_r >>> (monitor2_pkg::PU_FRAC + 1 - monitor2_pkg::CODE_W))
        + $signed({{(monitor2_pkg::WIDE_W-monitor2_pkg::CODE_W){1'b0}}, monitor2_pkg::CODE_MID});
    end
    sat_nxt = 1'b1;
    if (pre_code < 0)
    begin
      code_nxt = '0;
    end
    else if (pre_code > $signed({{(monitor2_pkg::WIDE_W-monitor2_pkg::CODE_W){1'b0}}, monitor2_pkg::CODE_MAX}))
    begin
      code_nxt = monitor2_pkg::CODE_MAX;
    end
    else
    begin
      code_nxt = pre_code[monitor2_pkg::CODE_W-1:0];
      sat_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_r <= monitor2_pkg::CODE_RST;
      update_r <= 1'b0;
    end
    else
    begin
      update_r <= scaled_vld_r;
      if (scaled_vld_r)
      begin
        code_r <= code_nxt;
      end
    end
  end

  // Status capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r <= '{enum_mode: 1'b0, saturated: 1'b0, code: monitor2_pkg::CODE_RST};
    end
    else if (scaled_vld_r)
    begin
      stat_r <= '{enum_mode: enum_mode_r, saturated: sat_nxt, code: code_nxt};
    end
  end

  assign reg_rdata = rdata_r;
  assign var_pointer = ctrl_r.pointer;
  assign dac_code = code_r;
  assign dac_update = update_r;

endmodule : dac_monitor_channel_two

/* File: tb/monitor2_asserts.sv */
module monitor2_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [13:0] var_pointer,
  input wire logic [31:0] var_data,
  input wire logic var_valid,
  input wire logic [11:0] dac_code,
  input wire logic dac_update
);
  logic [8:0] g_r;
  wire wc = reg_wr && reg_addr == monitor2_pkg::CTRL_ADDR;
  wire rc = reg_rd && reg_addr == monitor2_pkg::CTRL_ADDR;
  // Shadow of exponent, fraction and polarity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      g_r <= 9'h010;
    else if (wc)
      g_r <= reg_wdata[22:14];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PTR_WR: assert property (wc |=> var_pointer == $past(reg_wdata[13:0])) else $error("ptr");
  AST_PTR_RD: assert property (rc |=> reg_rdata == {18'h0, var_pointer}) else $error("rd");
  AST_LAT: assert property (var_valid |-> ##2 dac_update) else $error("upd");
  AST_UNI: assert property (var_valid && g_r[0] && var_data == 32'h0 |-> ##2 dac_code == 12'h0)
    else $error("uni");
  AST_BI: assert property (var_valid && !g_r[0] && var_data == 32'h0 |-> ##2 dac_code == 12'h800)
    else $error("bi");
  AST_ENUM: assert property (var_valid && g_r == 9'h000 && var_data == 32'h1f |-> ##2 dac_code == 12'hfc0)
    else $error("enum");
  AST_EXP: assert property (var_valid && g_r == 9'h041 && var_data == 32'h4 |-> ##2 dac_code == 12'h800)
    else $error("exp");
  AST_SAT: assert property (var_valid && g_r[0] && var_data[31] |-> ##2 dac_code == 12'h0)
    else $error("sat");
  COV_ENUM: cover property (var_valid && g_r[4:1] == 4'h0);
  COV_TOP: cover property (dac_update && dac_code == 12'hfff);
  COV_RD: cover property (rc);
endmodule : monitor2_asserts
bind dac_monitor_channel_two monitor2_asserts i_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .var_pointer, .var_data, .var_valid, .dac_code, .dac_update);

/* File: tb/test_dac_monitor_channel_two.sv */
module test_dac_monitor_channel_two;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, var_valid = 1'b0, dac_update;
  logic [11:0] reg_addr = 12'h0, dac_code;
  logic [31:0] reg_wdata = 32'h0, var_data = 32'h0, reg_rdata;
  logic [13:0] var_pointer;
  monitor2_pkg::ctrl_t c;
  int fail_count = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  dac_monitor_channel_two i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .var_pointer, .var_data, .var_valid, .dac_code, .dac_update);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic wr(logic [11:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
    @(posedge clk);
  endtask : rd
  // Model: scale, map, clamp
  task automatic run(monitor2_pkg::ctrl_t cc, logic [31:0] v);
    longint s;
    longint q;
    wr(monitor2_pkg::CTRL_ADDR, {9'h0, cc});
    var_data <= v;
    var_valid <= 1'b1;
    @(posedge clk);
    var_valid <= 1'b0;
    var_data <= ~v;
    @(posedge clk);
    #1;
    s = longint'(signed'(v));
    s = cc.frac_gain != 4'h0 ? (s * longint'(cc.frac_gain)) >>> 3 : s <<< (22 + cc.exp_gain);
    s = cc.polarity ? s >>> 15 : (s >>> 16) + 2048;
    q = s < 0 ? 0 : s > 4095 ? 4095 : s;
    chk("code", 32'(q), {20'h0, dac_code});
    chk("update", 32'h1, {31'h0, dac_update});
    @(posedge clk);
    rd(monitor2_pkg::CTRL_ADDR, {18'h0, cc.pointer});
    rd(monitor2_pkg::STAT_ADDR, {14'h0, cc.frac_gain == 4'h0, s < 0 || s > 4095, 4'h0, 12'(q)});
  endtask : run
  initial
  begin
    void'($urandom(21134));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset code", 32'h800, {20'h0, dac_code});
    @(posedge clk);
    rd(monitor2_pkg::CTRL_ADDR, 32'h0);
    wr(12'h3e0, 32'hffffffff);
    rd(12'h3e0, 32'h0);
    rd(monitor2_pkg::CTRL_ADDR, 32'h0);
    run({4'h0, 4'h8, 1'b0, 14'h0}, 32'h0);
    run({4'h0, 4'h8, 1'b1, 14'h3fff}, 32'h0);
    run({4'h0, 4'h0, 1'b0, 14'h1}, 32'h1f);
    run({4'h2, 4'h0, 1'b1, 14'h2}, 32'h4);
    run({4'h0, 4'h8, 1'b1, 14'h3}, 32'h80000000);
    run({4'h0, 4'hf, 1'b0, 14'h4}, 32'h7fffffff);
    for (int i = 0; i < 48; i++)
    begin
      c = 23'($urandom);
      c.frac_gain = i[3:0];
      c.polarity = i[4];
      run(c, (i % 16 != 0) ? $urandom : $urandom % 32);
    end
    finish_test();
  end
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : test_dac_monitor_channel_two
